// File: rac_defines.svh
// Constants of the recorder address controller: command codes, register offsets, field positions, limits.
// Included by bare name wherever a constant is needed.
`ifndef RAC_DEFINES_SVH
`define RAC_DEFINES_SVH

`define RAC_CMD_NOP        4'h0
`define RAC_CMD_ADDR_WRITE 4'h1
`define RAC_CMD_ADDR_READ  4'h2
`define RAC_CMD_REC        4'h3
`define RAC_CMD_PLAY       4'h4
`define RAC_CMD_START      4'h5
`define RAC_CMD_STOP       4'h6

`define RAC_OFF_CMD        4'h0
`define RAC_OFF_ADDR       4'h4
`define RAC_OFF_STATUS     4'h8
`define RAC_OFF_READBACK   4'hc

`define RAC_CMD_CODE_LSB   0
`define RAC_CMD_CHAN_LSB   4
`define RAC_CMD_MODE_BIT   7
`define RAC_CMD_FLEX_BIT   8
`define RAC_ST_BUSY_BIT    0
`define RAC_ST_ACTIVE_BIT  1
`define RAC_ST_PEND_BIT    2

`define RAC_WORD_START_LSB 20
`define RAC_MEM_TOP        20'hfffff
`define RAC_ADDR_ONE       20'h00001
`define RAC_ADDR_ZERO      20'h00000
`define RAC_Y_ZERO         8'h00
`define RAC_FIXED_LOW      17'h00000
`define RAC_FIXED_HIGH     17'h1ffff
`define RAC_CHAN_FIRST     3'h0
`define RAC_RESP_OKAY      2'h0

`endif

// File: rac_pkg.sv
// Types of the recorder address controller: the link command code, and the address and state types of the device end.
// Assumes the constants header is compiled alongside.
package rac_pkg;

   typedef logic [3:0]  rac_cmd_t;
   typedef logic [19:0] rac_addr_t;

   typedef enum logic [2:0] {
      RAC_IDLE  = 3'b000,
      RAC_FETCH = 3'b001,
      RAC_XFER  = 3'b011,
      RAC_RUN   = 3'b010,
      RAC_WBACK = 3'b110
   } rac_state_e;

endpackage

// File: rac_link_if.sv
// Command link between the host controller and the recorder address controller.
// Both ends run on the same clock; the host offers a command only while the device is not busy.
`timescale 1ns/1ps
interface rac_link_if;
   logic                cmd_valid;
   rac_pkg::rac_cmd_t   cmd_code;
   logic [2:0]          cmd_chan;
   logic                cmd_ctrl_mode;
   logic                cmd_flex;
   logic [31:0]         cmd_word;
   logic                busy;
   logic                active;
   logic [31:0]         rd_word;

   modport dev  (input  cmd_valid, cmd_code, cmd_chan, cmd_ctrl_mode, cmd_flex, cmd_word,
                 output busy, active, rd_word);
   modport host (output cmd_valid, cmd_code, cmd_chan, cmd_ctrl_mode, cmd_flex, cmd_word,
                 input  busy, active, rd_word);
endinterface

// File: rac_host.sv
// Host end: AXI4-Lite register slave that turns software writes into link commands.
// Assumes the device end shares I_SYS_CLK and takes a command in any cycle it is not busy.
`timescale 1ns/1ps
`include "rac_defines.svh"
module rac_host (
   // Clock and reset
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_RST,
   // AXI4-Lite slave
   input  wire logic [3:0]  I_AXI_AWADDR,
   input  wire logic        I_AXI_AWVALID,
   output logic             O_AXI_AWREADY,
   input  wire logic [31:0] I_AXI_WDATA,
   input  wire logic [3:0]  I_AXI_WSTRB,
   input  wire logic        I_AXI_WVALID,
   output logic             O_AXI_WREADY,
   output logic [1:0]       O_AXI_BRESP,
   output logic             O_AXI_BVALID,
   input  wire logic        I_AXI_BREADY,
   input  wire logic [3:0]  I_AXI_ARADDR,
   input  wire logic        I_AXI_ARVALID,
   output logic             O_AXI_ARREADY,
   output logic [31:0]      O_AXI_RDATA,
   output logic [1:0]       O_AXI_RRESP,
   output logic             O_AXI_RVALID,
   input  wire logic        I_AXI_RREADY,
   // Link to the device
   rac_link_if.host         LINK
);
   logic        aw_have_q;
   logic [3:0]  aw_addr_q;
   logic        w_have_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        bvalid_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [31:0] cmd_q;
   logic [31:0] addr_q;
   logic        pend_q;

   wire aw_take   = I_AXI_AWVALID & ~aw_have_q;
   wire w_take    = I_AXI_WVALID & ~w_have_q;
   wire do_write  = aw_have_q & w_have_q & ~bvalid_q;
   wire wr_cmd    = do_write & (aw_addr_q == `RAC_OFF_CMD) & w_strb_q[0];
   wire wr_addr   = do_write & (aw_addr_q == `RAC_OFF_ADDR);
   wire ar_take   = I_AXI_ARVALID & ~rvalid_q;
   // One command waits here while the device is busy; a second write before it fires replaces it.
   wire cmd_fire  = pend_q & ~LINK.busy;
   wire [31:0] status_word = {29'h0000000, pend_q, LINK.active, LINK.busy};
   wire [31:0] rd_mux = (I_AXI_ARADDR == `RAC_OFF_CMD)      ? cmd_q :
                        (I_AXI_ARADDR == `RAC_OFF_ADDR)     ? addr_q :
                        (I_AXI_ARADDR == `RAC_OFF_STATUS)   ? status_word :
                        (I_AXI_ARADDR == `RAC_OFF_READBACK) ? LINK.rd_word : 32'h00000000;

   assign O_AXI_AWREADY = ~aw_have_q;
   assign O_AXI_WREADY  = ~w_have_q;
   assign O_AXI_BVALID  = bvalid_q;
   assign O_AXI_BRESP   = `RAC_RESP_OKAY;
   assign O_AXI_ARREADY = ~rvalid_q;
   assign O_AXI_RVALID  = rvalid_q;
   assign O_AXI_RDATA   = rdata_q;
   assign O_AXI_RRESP   = `RAC_RESP_OKAY;

   assign LINK.cmd_valid     = cmd_fire;
   assign LINK.cmd_code      = cmd_q[`RAC_CMD_CODE_LSB +: 4];
   assign LINK.cmd_chan      = cmd_q[`RAC_CMD_CHAN_LSB +: 3];
   assign LINK.cmd_ctrl_mode = cmd_q[`RAC_CMD_MODE_BIT];
   assign LINK.cmd_flex      = cmd_q[`RAC_CMD_FLEX_BIT];
   assign LINK.cmd_word      = addr_q;

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 4'h0;
         w_have_q  <= 1'b0;
         w_data_q  <= 32'h00000000;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
      end else begin
         if (aw_take) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= I_AXI_AWADDR;
         end else if (do_write) begin
            aw_have_q <= 1'b0;
         end
         if (w_take) begin
            w_have_q <= 1'b1;
            w_data_q <= I_AXI_WDATA;
            w_strb_q <= I_AXI_WSTRB;
         end else if (do_write) begin
            w_have_q <= 1'b0;
         end
         if (do_write) begin
            bvalid_q <= 1'b1;
         end else if (I_AXI_BREADY) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_mux;
      end else if (I_AXI_RREADY) begin
         rvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         cmd_q  <= 32'h00000000;
         pend_q <= 1'b0;
      end else begin
         if (wr_cmd) begin
            cmd_q <= w_data_q;
         end
         pend_q <= wr_cmd | (pend_q & ~cmd_fire);
      end
   end

   genvar b;
   generate
      for (b = 0; b < 4; b = b + 1) begin : g_addr_byte
         always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
            if (I_RST) begin
               addr_q[8*b +: 8] <= 8'h00;
            end else if (wr_addr & w_strb_q[b]) begin
               addr_q[8*b +: 8] <= w_data_q[8*b +: 8];
            end
         end
      end
   endgenerate
endmodule

// File: rac_device.sv
// Device end: address counter, stop register and channel index area of the voice recorder.
// Assumes the host offers commands only while busy is low and I_DATA_TICK comes from logic on I_SYS_CLK.
//
// Behaviour
// - Direct mode: address write fills channel slot.
// - Direct start: index to counter via address register.
// - After loading, run and count per data.
// - Record stop writes counter as new stop.
// - Fixed start: generated addresses, also stored.
// - Flex start: read preceding channel stop address.
// - Flex start address is preceding stop plus one.
// - Flex stop address is memory top, stored.
// - Playback start loads stored addresses, counts up.
// - Playback stop leaves counter and index alone.
// - Host keeps multi-channel addresses, uses direct mode.
// - Host reads stop address back after recording.
// - Host writes saved addresses before playback start.
// - X address decodes into four memory selects.
// - First select must hold a serial register.
// - Host keeps thirty-two address bits per word.
// - Host adds select offset to X addresses.
// - Host loads ROM word addresses into a channel.
// - Counter equal to stop ends; flag reports.
// - Channel command carries channel and control mode.
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "rac_defines.svh"
module rac_device (
   // Clock and reset
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_RST,
   // Link to the host
   rac_link_if.dev          LINK,
   // Voice memory side
   input  wire logic        I_DATA_TICK,
   output logic [19:0]      O_MEM_ADDR,
   output logic [3:0]       O_VOICE_MEM_SELECT_N,
   output logic             O_RECORDING,
   output logic             O_PLAYING
);
   rac_pkg::rac_state_e state_q;
   rac_pkg::rac_state_e state_d;
   rac_pkg::rac_addr_t  idx_start_q [0:7];
   rac_pkg::rac_addr_t  idx_stop_q  [0:7];
   rac_pkg::rac_addr_t  areg_start_q;
   rac_pkg::rac_addr_t  areg_stop_q;
   rac_pkg::rac_addr_t  cnt_q;
   rac_pkg::rac_addr_t  stop_q;
   logic [2:0]          chan_q;
   logic                ctrl_mode_q;
   logic                flex_q;
   logic                rec_q;
   logic                active_q;
   logic [31:0]         rd_word_q;
   logic [3:0]          sel_q;

   wire in_idle    = (state_q == rac_pkg::RAC_IDLE);
   wire in_run     = (state_q == rac_pkg::RAC_RUN);
   wire in_fetch   = (state_q == rac_pkg::RAC_FETCH);
   wire in_xfer    = (state_q == rac_pkg::RAC_XFER);
   wire in_wback   = (state_q == rac_pkg::RAC_WBACK);
   wire take       = LINK.cmd_valid & (in_idle | in_run);
   wire cmd_addr_w = take & in_idle & (LINK.cmd_code == `RAC_CMD_ADDR_WRITE);
   wire cmd_addr_r = take & in_idle & (LINK.cmd_code == `RAC_CMD_ADDR_READ);
   wire cmd_rec    = take & in_idle & (LINK.cmd_code == `RAC_CMD_REC);
   wire cmd_play   = take & in_idle & (LINK.cmd_code == `RAC_CMD_PLAY);
   wire cmd_start  = take & in_idle & (LINK.cmd_code == `RAC_CMD_START);
   wire cmd_stop   = take & in_run & (LINK.cmd_code == `RAC_CMD_STOP);
   wire at_stop    = (cnt_q == stop_q);
   wire run_end    = in_run & I_DATA_TICK & at_stop;

   // Generated or fetched addresses depend on the control mode latched by start and the record flag latched by the record or play command.
   wire gen_mode   = rec_q & ctrl_mode_q;
   wire [2:0] prev_chan = chan_q - 3'h1;
   wire rac_pkg::rac_addr_t prev_stop = idx_stop_q[prev_chan];
   wire rac_pkg::rac_addr_t flex_start =
      (chan_q == `RAC_CHAN_FIRST) ? `RAC_ADDR_ZERO :
      prev_stop + `RAC_ADDR_ONE;
   wire rac_pkg::rac_addr_t fixed_start = {chan_q, `RAC_FIXED_LOW};
   wire rac_pkg::rac_addr_t fixed_stop  = {chan_q, `RAC_FIXED_HIGH};
   wire rac_pkg::rac_addr_t gen_start = flex_q ? flex_start : fixed_start;
   wire rac_pkg::rac_addr_t gen_stop  = flex_q ? `RAC_MEM_TOP : fixed_stop;
   wire rac_pkg::rac_addr_t load_start = gen_mode ? gen_start : idx_start_q[chan_q];
   wire rac_pkg::rac_addr_t load_stop  = gen_mode ? gen_stop : idx_stop_q[chan_q];

   // Index area write port: address write, generated addresses at fetch, or stop write-back.
   wire wr_chan_sel_cmd = cmd_addr_w;
   wire [2:0] idx_wchan = wr_chan_sel_cmd ? LINK.cmd_chan : chan_q;
   wire idx_we_start = cmd_addr_w | (in_fetch & gen_mode);
   wire idx_we_stop  = cmd_addr_w | (in_fetch & gen_mode) | in_wback;
   wire rac_pkg::rac_addr_t idx_wd_start =
      cmd_addr_w ? {LINK.cmd_word[31:`RAC_WORD_START_LSB], `RAC_Y_ZERO} : gen_start;
   wire rac_pkg::rac_addr_t idx_wd_stop =
      cmd_addr_w ? LINK.cmd_word[19:0] : (in_wback ? cnt_q : gen_stop);

   assign LINK.busy     = ~(in_idle | in_run);
   assign LINK.active   = active_q;
   assign LINK.rd_word  = rd_word_q;
   assign O_MEM_ADDR    = cnt_q;
   assign O_VOICE_MEM_SELECT_N = ~sel_q;
   assign O_RECORDING   = active_q & rec_q;
   assign O_PLAYING     = active_q & ~rec_q;

   always_comb begin
      state_d = state_q;
      case (state_q)
         rac_pkg::RAC_IDLE: begin
            if (cmd_start) begin
               state_d = rac_pkg::RAC_FETCH;
            end
         end
         rac_pkg::RAC_FETCH: begin
            state_d = rac_pkg::RAC_XFER;
         end
         rac_pkg::RAC_XFER: begin
            state_d = rac_pkg::RAC_RUN;
         end
         rac_pkg::RAC_RUN: begin
            if (cmd_stop & rec_q) begin
               state_d = rac_pkg::RAC_WBACK;
            end else if (cmd_stop | run_end) begin
               state_d = rac_pkg::RAC_IDLE;
            end
         end
         rac_pkg::RAC_WBACK: begin
            state_d = rac_pkg::RAC_IDLE;
         end
         default: begin
            state_d = rac_pkg::RAC_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         state_q <= rac_pkg::RAC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         chan_q      <= 3'h0;
         ctrl_mode_q <= 1'b0;
         flex_q      <= 1'b0;
         rec_q       <= 1'b0;
      end else begin
         if (cmd_start) begin
            chan_q      <= LINK.cmd_chan;
            ctrl_mode_q <= LINK.cmd_ctrl_mode;
            flex_q      <= LINK.cmd_flex;
         end
         if (cmd_rec | cmd_play) begin
            rec_q <= cmd_rec;
         end
      end
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         areg_start_q <= `RAC_ADDR_ZERO;
         areg_stop_q  <= `RAC_ADDR_ZERO;
      end else if (in_fetch) begin
         areg_start_q <= load_start;
         areg_stop_q  <= load_stop;
      end
   end

   // Counting stops on the matching tick, so the counter keeps the end address for read-back.
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         cnt_q    <= `RAC_ADDR_ZERO;
         stop_q   <= `RAC_ADDR_ZERO;
         active_q <= 1'b0;
      end else begin
         if (in_xfer) begin
            cnt_q    <= areg_start_q;
            stop_q   <= areg_stop_q;
            active_q <= 1'b1;
         end else if (in_run & (cmd_stop | run_end)) begin
            active_q <= 1'b0;
         end else if (in_run & I_DATA_TICK) begin
            cnt_q <= cnt_q + `RAC_ADDR_ONE;
         end
      end
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         rd_word_q <= 32'h00000000;
      end else if (cmd_addr_r) begin
         rd_word_q <= {idx_start_q[LINK.cmd_chan][19:8], idx_stop_q[LINK.cmd_chan]};
      end
   end

   genvar e;
   generate
      for (e = 0; e < 8; e = e + 1) begin : g_index
         always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
            if (I_RST) begin
               idx_start_q[e] <= `RAC_ADDR_ZERO;
               idx_stop_q[e]  <= `RAC_ADDR_ZERO;
            end else if (idx_wchan == 3'(e)) begin
               if (idx_we_start) begin
                  idx_start_q[e] <= idx_wd_start;
               end
               if (idx_we_stop) begin
                  idx_stop_q[e] <= idx_wd_stop;
               end
            end
         end
      end
      // Each select covers one quarter of the X space; the first must be a serial register.
      for (e = 0; e < 4; e = e + 1) begin : g_select
         always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
            if (I_RST) begin
               sel_q[e] <= 1'b0;
            end else begin
               sel_q[e] <= active_q & (cnt_q[19:18] == 2'(e));
            end
         end
      end
   endgenerate
endmodule

// File: rac_properties.sv
// Concurrent checks on the command link and memory side of the recorder address controller.
// Assumes one clock domain and a bench that instantiates it beside the link interface.
`timescale 1ns/1ps
`include "rac_defines.svh"
module rac_properties (
   // Clock and reset
   input  wire logic              I_SYS_CLK,
   input  wire logic              I_RST,
   // Link signals
   input  wire logic              cmd_valid,
   input  wire rac_pkg::rac_cmd_t cmd_code,
   input  wire logic              busy,
   input  wire logic              active,
   // Memory side
   input  wire logic              I_DATA_TICK,
   input  wire logic [19:0]       O_MEM_ADDR,
   input  wire logic [3:0]        O_VOICE_MEM_SELECT_N,
   input  wire logic              O_RECORDING,
   input  wire logic              O_PLAYING
);
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RST);
   wire       start_c = cmd_valid && cmd_code == `RAC_CMD_START && !busy && !active;
   wire       stop_c  = cmd_valid && cmd_code == `RAC_CMD_STOP && active;
   wire [3:0] sel_dec = active ? (4'h1 << O_MEM_ADDR[19:18]) : 4'h0;
   sequence s_load;
      busy ##1 busy ##1 (!busy && active);
   endsequence
   sequence s_wback;
      (busy && !active) ##1 !busy;
   endsequence
   // Ticks that coincide with a command are left out because the stop edge has its own check.
   a_start_load: assert property (start_c |=> s_load) else $error("start load timing wrong");
   a_stop_rec_back: assert property (stop_c && O_RECORDING |=> s_wback) else $error("no write back");
   a_stop_play_keep: assert property (stop_c && O_PLAYING && !I_DATA_TICK |=>
      !busy && !active && $stable(O_MEM_ADDR)) else $error("play stop changed state");
   a_tick_count: assert property (active && I_DATA_TICK && !cmd_valid |=>
      !active || O_MEM_ADDR == $past(O_MEM_ADDR) + `RAC_ADDR_ONE) else $error("counter did not step");
   a_idle_hold: assert property (active && !I_DATA_TICK && !cmd_valid |=> $stable(O_MEM_ADDR))
      else $error("counter moved without data");
   a_match_end: assert property ($fell(active) && !$past(cmd_valid) |->
      $past(I_DATA_TICK) && !busy && $stable(O_MEM_ADDR)) else $error("bad end of transfer");
   a_flag_match: assert property ((O_RECORDING || O_PLAYING) == active && !(O_RECORDING && O_PLAYING))
      else $error("mode flags disagree with active");
   a_select_map: assert property (O_VOICE_MEM_SELECT_N == ~$past(sel_dec)) else $error("select decode wrong");
   a_cmd_idle: assert property (cmd_valid |-> !busy) else $error("command while busy");
endmodule

// File: rac_tb_top.sv
// Testbench of the recorder address controller: host and device joined by the link, driven over AXI4-Lite.
// Assumes both design ends, the link interface and the property checker are compiled first.
`timescale 1ns/1ps
`include "rac_defines.svh"
module rac_tb_top;
   localparam int LIMIT = 20000;
   logic        clk        = 1'h0;
   logic        rst        = 1'h1;
   logic [3:0]  awaddr     = 4'h0;
   logic        awvalid    = 1'h0;
   logic        awready;
   logic [31:0] wdata      = 32'h0;
   logic        wvalid     = 1'h0;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready     = 1'h0;
   logic [3:0]  araddr     = 4'h0;
   logic        arvalid    = 1'h0;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready     = 1'h0;
   logic        tick       = 1'h0;
   logic [19:0] mem_addr;
   logic [3:0]  sel_n;
   logic        rec;
   logic        play;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          n_cycles   = 0;

   rac_link_if rac_link_if_i ();
   rac_host rac_host_i (.I_SYS_CLK(clk), .I_RST(rst), .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid),
      .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'hf), .I_AXI_WVALID(wvalid),
      .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
      .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready), .O_AXI_RDATA(rdata),
      .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready), .LINK(rac_link_if_i));
   rac_device rac_device_i (.I_SYS_CLK(clk), .I_RST(rst), .LINK(rac_link_if_i), .I_DATA_TICK(tick),
      .O_MEM_ADDR(mem_addr), .O_VOICE_MEM_SELECT_N(sel_n), .O_RECORDING(rec), .O_PLAYING(play));
   rac_properties rac_properties_i (.I_SYS_CLK(clk), .I_RST(rst), .cmd_valid(rac_link_if_i.cmd_valid),
      .cmd_code(rac_link_if_i.cmd_code), .busy(rac_link_if_i.busy), .active(rac_link_if_i.active),
      .I_DATA_TICK(tick), .O_MEM_ADDR(mem_addr), .O_VOICE_MEM_SELECT_N(sel_n), .O_RECORDING(rec),
      .O_PLAYING(play));

   always #10 clk = ~clk;

   task automatic print_verdict();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   always @(posedge clk) begin
      n_cycles <= n_cycles + 1;
      if (n_cycles == LIMIT) begin
         n_mismatch++;
         print_verdict();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Ready and valid are sampled mid-cycle so the release at the next edge never races the design.
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
      logic ra;
      logic rw;
      logic rb;
      rb = 1'h0;
      @(posedge clk);
      awaddr  <= a;
      awvalid <= 1'h1;
      wdata   <= v;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      while (!rb) begin
         @(negedge clk);
         ra = awvalid && awready;
         rw = wvalid && wready;
         rb = bvalid;
         if (rb)
            check(32'(bresp), 32'(`RAC_RESP_OKAY));
         @(posedge clk);
         if (ra)
            awvalid <= 1'h0;
         if (rw)
            wvalid <= 1'h0;
      end
      bready <= 1'h0;
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] v);
      logic ra;
      logic rv;
      rv = 1'h0;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      while (!rv) begin
         @(negedge clk);
         ra = arvalid && arready;
         rv = rvalid;
         v  = rdata;
         if (rv)
            check(32'(rresp), 32'(`RAC_RESP_OKAY));
         @(posedge clk);
         if (ra)
            arvalid <= 1'h0;
      end
      rready <= 1'h0;
   endtask

   task automatic cmd(input logic [3:0] code, input logic [2:0] ch, input logic mode, input logic flex);
      logic [31:0] st;
      st = 32'h5;
      axi_wr(`RAC_OFF_CMD, {23'h0, flex, mode, ch, code});
      while (st[2] !== 1'h0 || st[0] !== 1'h0)
         axi_rd(`RAC_OFF_STATUS, st);
   endtask

   task automatic addr_wr(input logic [2:0] ch, input logic [11:0] sx, input logic [19:0] sp);
      axi_wr(`RAC_OFF_ADDR, {sx, sp});
      cmd(`RAC_CMD_ADDR_WRITE, ch, 1'h0, 1'h0);
   endtask

   task automatic addr_chk(input logic [2:0] ch, input logic [31:0] exp);
      logic [31:0] v;
      cmd(`RAC_CMD_ADDR_READ, ch, 1'h0, 1'h0);
      axi_rd(`RAC_OFF_READBACK, v);
      check(v, exp);
   endtask

   // Ticks end one step past the edge so checks see settled outputs.
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk);
         tick <= 1'h1;
         @(posedge clk);
         tick <= 1'h0;
      end
      @(posedge clk);
      #1;
   endtask

   task automatic t_direct();
      addr_wr(3'h1, 12'h010, 20'h01003);
      addr_chk(3'h1, 32'h01001003);
      cmd(`RAC_CMD_REC, 3'h1, 1'h0, 1'h0);
      cmd(`RAC_CMD_START, 3'h1, 1'h0, 1'h0);
      ticks(0);
      check(32'(mem_addr), 32'h01000);
      check(32'(sel_n), 32'he);
      ticks(3);
      check(32'(mem_addr), 32'h01003);
      check(32'(rec), 32'h1);
      ticks(1);
      check(32'(rec), 32'h0);
      check(32'(mem_addr), 32'h01003);
   endtask

   task automatic t_stop_rec();
      addr_wr(3'h2, 12'h800, 20'h80fff);
      cmd(`RAC_CMD_START, 3'h2, 1'h0, 1'h0);
      ticks(5);
      check(32'(sel_n), 32'hb);
      cmd(`RAC_CMD_STOP, 3'h2, 1'h0, 1'h0);
      addr_chk(3'h2, 32'h80080005);
   endtask

   // The second part plays a ROM word whose X addresses carry the second select's offset.
   task automatic t_play();
      cmd(`RAC_CMD_PLAY, 3'h2, 1'h0, 1'h0);
      cmd(`RAC_CMD_START, 3'h2, 1'h1, 1'h0);
      ticks(2);
      check(32'(mem_addr), 32'h80002);
      check(32'(play), 32'h1);
      cmd(`RAC_CMD_STOP, 3'h2, 1'h0, 1'h0);
      ticks(0);
      check(32'(mem_addr), 32'h80002);
      addr_chk(3'h2, 32'h80080005);
      addr_wr(3'h0, 12'h000 + 12'h400, {12'h010 + 12'h400, 8'h5d});
      cmd(`RAC_CMD_START, 3'h0, 1'h0, 1'h0);
      ticks(0);
      check(32'(mem_addr), 32'h40000);
      check(32'(sel_n), 32'hd);
      cmd(`RAC_CMD_STOP, 3'h0, 1'h0, 1'h0);
   endtask

   task automatic t_fixed_flex();
      cmd(`RAC_CMD_REC, 3'h3, 1'h1, 1'h0);
      cmd(`RAC_CMD_START, 3'h3, 1'h1, 1'h0);
      ticks(0);
      check(32'(mem_addr), 32'h60000);
      check(32'(sel_n), 32'hd);
      ticks(1);
      cmd(`RAC_CMD_STOP, 3'h3, 1'h1, 1'h0);
      addr_chk(3'h3, 32'h60060001);
      cmd(`RAC_CMD_START, 3'h4, 1'h1, 1'h1);
      ticks(0);
      check(32'(mem_addr), 32'h60002);
      cmd(`RAC_CMD_STOP, 3'h4, 1'h1, 1'h1);
      addr_chk(3'h4, 32'h60060002);
      cmd(`RAC_CMD_START, 3'h0, 1'h1, 1'h1);
      ticks(0);
      check(32'(mem_addr), 32'h00000);
      cmd(`RAC_CMD_STOP, 3'h0, 1'h1, 1'h1);
      // A flex channel just below the top runs into the memory top and ends there by match.
      addr_wr(3'h6, 12'h000, 20'hffffd);
      cmd(`RAC_CMD_START, 3'h7, 1'h1, 1'h1);
      ticks(0);
      check(32'(mem_addr), 32'hffffe);
      check(32'(sel_n), 32'h7);
      ticks(2);
      check(32'(mem_addr), 32'hfffff);
      check(32'(rec), 32'h0);
      addr_chk(3'h7, 32'hffffffff);
   endtask

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      t_direct();
      t_stop_rec();
      t_play();
      t_fixed_flex();
      print_verdict();
   end
endmodule
